// *** usart_ctrl_pkg.sv ***
// Register map, field positions and constants of the serial transceiver control block
package usart_ctrl_pkg;
  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [3:0] IDX_RX_DATA_LO = 4'h0;
  localparam logic [3:0] IDX_RX_DATA_HI = 4'h1;
  localparam logic [3:0] IDX_TX_DATA_LO = 4'h2;
  localparam logic [3:0] IDX_TX_DATA_HI = 4'h3;
  localparam logic [3:0] IDX_STATUS = 4'h4;
  localparam logic [3:0] IDX_CTRL_A = 4'h5;
  localparam logic [3:0] IDX_CTRL_B = 4'h6;
  localparam logic [3:0] IDX_CTRL_C = 4'h7;
  // ==========================================================================
  // interrupt_and_line_control fields
  localparam int RX_DONE_IRQ_EN = 7;
  localparam int TX_DONE_IRQ_EN = 6;
  localparam int TX_EMPTY_IRQ_EN = 5;
  localparam int FRAME_START_IRQ_EN = 4;
  localparam int LOOP_BACK_EN = 3;
  localparam int BAUD_DETECT_ERR_IRQ_EN = 2;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [1:0] RS485_OFF = 2'h0;
  localparam logic [1:0] RS485_EXT = 2'h1;
  localparam logic [1:0] RS485_INT = 2'h2;
  // ==========================================================================
  // receiver_transmitter_control fields
  localparam int RECEIVER_ON = 7;
  localparam int TRANSMITTER_ON = 6;
  localparam int FRAME_START_WAKE_EN = 4;
  localparam int OPEN_DRAIN_EN = 3;
  localparam int SPEED_LSB = 1;
  localparam int ADDRESS_FRAME_FILTER = 0;
  localparam logic [7:0] CTRL_B_MASK = 8'hdf;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [1:0] SPEED_NORMAL = 2'h0;
  localparam logic [1:0] SPEED_DOUBLE = 2'h1;
  localparam logic [1:0] SPEED_GENERIC_AUTO = 2'h2;
  localparam logic [1:0] SPEED_CONSTRAINED_AUTO = 2'h3;
  // ==========================================================================
  // frame_format_control fields
  localparam logic [1:0] COMM_ASYNC = 2'h0;
  localparam logic [1:0] COMM_SYNC = 2'h1;
  localparam logic [1:0] COMM_INFRARED = 2'h2;
  localparam logic [1:0] COMM_SPI_HOST = 2'h3;
  localparam logic [1:0] PARITY_EVEN = 2'h2;
  localparam logic [1:0] PARITY_ODD = 2'h3;
  localparam int STOP_BIT_SEL = 3;
  localparam logic [5:0] FMT_ASYNC_RESET = 6'h03;
  localparam logic [2:0] FMT_SPI_RESET = 3'h0;
  localparam logic [2:0] CHAR_NINE_LOW_FIRST = 3'h6;
  localparam logic [2:0] CHAR_NINE_HIGH_FIRST = 3'h7;
  // ==========================================================================
  // Status and received-data bit positions
  localparam int ST_RX_DONE = 7;
  localparam int ST_TX_DONE = 6;
  localparam int ST_TX_EMPTY = 5;
  localparam int ST_FRAME_START = 4;
  localparam int ST_BAD_SYNC = 3;
  localparam int RXH_OVERRUN = 6;
  localparam int RXH_FRAMING = 2;
  localparam int RXH_PARITY = 1;
  // ==========================================================================
  // Baud sampling
  localparam logic [7:0] SAMPLES_NORMAL = 8'h10;
  localparam logic [7:0] SAMPLES_DOUBLE = 8'h08;
  localparam logic [7:0] TWO_BIT_NOMINAL = 8'h20;
  localparam logic [7:0] TWO_BIT_TOLERANCE = 8'h06;
  localparam logic [7:0] GENERIC_TWO_BIT_MIN = 8'h04;
  localparam logic [7:0] GENERIC_TWO_BIT_MAX = 8'hfe;
  localparam logic [2:0] SYNC_INTERVALS = 3'h4;
endpackage

// *** tx_link_if.sv ***
// Connection between the control block and its frame shifter
`timescale 1ns/10ps
interface tx_link_if;
  logic tick;
  logic start;
  logic [8:0] data;
  logic [3:0] nbits;
  logic par_en;
  logic par_odd;
  logic two_stop;
  logic [7:0] bit_len;
  logic busy;
  logic done;
  logic line;
  modport ctrl (output tick, start, data, nbits, par_en, par_odd, two_stop, bit_len, input busy, done, line);
  modport shifter (input tick, start, data, nbits, par_en, par_odd, two_stop, bit_len, output busy, done, line);
endinterface

// *** serial_frame_tx.sv ***
// Transmit shifter: start bit, data LSB first, optional parity, one or two stop bits
`timescale 1ns/10ps
module serial_frame_tx (
  input wire logic clk_sys,
  input wire logic reset_n,
  tx_link_if.shifter link
);
  typedef struct packed {
    logic busy;
    logic done;
    logic line;
    logic [7:0] cnt;
    logic [3:0] left;
    logic [12:0] frame;
  } tx_state_type;

  tx_state_type s_q;
  tx_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy && link.start) begin
      s_d.frame = '1;
      s_d.frame[0] = 1'b0;
      for (int i = 0; i < 9; i++) begin
        if (i < int'(link.nbits)) begin
          s_d.frame[1 + i] = link.data[i];
        end
      end
      if (link.par_en) begin
        s_d.frame[1 + int'(link.nbits)] = (^(link.data & ~(9'h1ff << link.nbits))) ^ link.par_odd;
      end
      s_d.left = 4'(4'h2 + link.nbits + {3'h0, link.par_en} + {3'h0, link.two_stop});
      s_d.busy = 1'b1;
      s_d.cnt = 8'h00;
      s_d.line = 1'b0;
    end else if (s_q.busy && link.tick) begin
      if (s_q.cnt == 8'(link.bit_len - 8'h01)) begin
        s_d.cnt = 8'h00;
        s_d.frame = {1'b1, s_q.frame[12:1]};
        s_d.left = 4'(s_q.left - 4'h1);
        if (s_q.left == 4'h1) begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.line = 1'b1;
        end else begin
          s_d.line = s_q.frame[1];
        end
      end else begin
        s_d.cnt = 8'(s_q.cnt + 8'h01);
      end
    end
    if (!reset_n) begin
      s_d = '0;
      s_d.line = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  assign link.busy = s_q.busy;
  assign link.done = s_q.done;
  assign link.line = s_q.line;
endmodule

// *** usart_control_config.sv ***
// Serial transceiver control, configuration, receiver and Avalon-MM register slave
`timescale 1ns/10ps
module usart_control_config #(
  parameter int SAMPLE_DIV = 4
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic rxd_in,
  input wire logic sleep_active,
  output logic txd_out,
  output logic txd_oe,
  output logic driver_enable_pin,
  output logic rx_pin_owned,
  output logic wake_req,
  output logic rx_vector_irq,
  output logic tx_vector_irq,
  output logic empty_vector_irq
);
  initial begin
    if (SAMPLE_DIV < 1 || SAMPLE_DIV > 255) begin
      $error("SAMPLE_DIV must lie in 1..255");
    end
  end

  localparam logic [7:0] TICK_LAST = 8'(SAMPLE_DIV - 1);

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_SYNC} rx_state_type;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [1:0] comm_mode_sel;
    logic [5:0] fmt_async;
    logic [2:0] fmt_spi;
    logic wait_q;
    logic [7:0] rdata;
    logic sync1;
    logic sync2;
    logic line_prev;
    logic [7:0] tick_cnt;
    logic tick;
    rx_state_type rx_state;
    logic [7:0] rx_cnt;
    logic [3:0] rx_bits;
    logic [8:0] rx_shift;
    logic rx_par;
    logic rx_parity_err_flag;
    logic [8:0] rxbuf;
    logic rxbuf_valid;
    logic framing_err_flag;
    logic parity_err_flag;
    logic overrun_flag;
    logic synced;
    logic [7:0] bit_len;
    logic [2:0] edges;
    logic bad_sync_flag;
    logic frame_start_flag;
    logic tx_done_flag;
    logic [8:0] txbuf;
    logic txbuf_valid;
    logic tx_start;
    logic tx_enabled;
    logic txd;
    logic txd_oe;
    logic de;
    logic wake;
    logic irq_rx;
    logic irq_tx;
    logic irq_dre;
  } main_state_type;

  main_state_type s_q;
  main_state_type s_d;

  tx_link_if link ();

  serial_frame_tx u_tx (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .link(link)
  );

  // ==========================================================================
  // Decoding shared by transmit and receive paths
  function automatic logic [3:0] char_bits(input logic [2:0] sel);
    unique case (sel)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      usart_ctrl_pkg::CHAR_NINE_LOW_FIRST, usart_ctrl_pkg::CHAR_NINE_HIGH_FIRST: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

  logic [1:0] rs485_sel;
  logic [1:0] receiver_speed_sel;
  logic [1:0] parity_sel;
  logic [2:0] char_width_sel;
  logic [3:0] nbits;
  logic parity_on;
  logic parity_odd;
  logic auto_mode;
  logic [7:0] bit_len_now;
  logic rx_line;
  logic line_fall;
  logic req;
  logic [3:0] idx;
  logic [7:0] wbyte;
  logic [7:0] two_bit_min;
  logic [7:0] two_bit_max;

  always_comb begin
    rs485_sel = s_q.ctrl_a[1:0];
    receiver_speed_sel = s_q.ctrl_b[usart_ctrl_pkg::SPEED_LSB +: 2];
    parity_sel = s_q.fmt_async[5:4];
    char_width_sel = s_q.fmt_async[2:0];
    nbits = char_bits(char_width_sel);
    parity_on = (parity_sel == usart_ctrl_pkg::PARITY_EVEN) || (parity_sel == usart_ctrl_pkg::PARITY_ODD);
    parity_odd = (parity_sel == usart_ctrl_pkg::PARITY_ODD);
    auto_mode = (receiver_speed_sel == usart_ctrl_pkg::SPEED_GENERIC_AUTO)
             || (receiver_speed_sel == usart_ctrl_pkg::SPEED_CONSTRAINED_AUTO);
    if (auto_mode && s_q.synced) begin
      bit_len_now = s_q.bit_len;
    end else if (receiver_speed_sel == usart_ctrl_pkg::SPEED_DOUBLE
                 && s_q.comm_mode_sel != usart_ctrl_pkg::COMM_SYNC) begin
      bit_len_now = usart_ctrl_pkg::SAMPLES_DOUBLE;
    end else begin
      bit_len_now = usart_ctrl_pkg::SAMPLES_NORMAL;
    end
    if (receiver_speed_sel == usart_ctrl_pkg::SPEED_CONSTRAINED_AUTO) begin
      two_bit_min = 8'(usart_ctrl_pkg::TWO_BIT_NOMINAL - usart_ctrl_pkg::TWO_BIT_TOLERANCE);
      two_bit_max = 8'(usart_ctrl_pkg::TWO_BIT_NOMINAL + usart_ctrl_pkg::TWO_BIT_TOLERANCE);
    end else begin
      two_bit_min = usart_ctrl_pkg::GENERIC_TWO_BIT_MIN;
      two_bit_max = usart_ctrl_pkg::GENERIC_TWO_BIT_MAX;
    end
    rx_line = s_q.ctrl_a[usart_ctrl_pkg::LOOP_BACK_EN] ? link.line : s_q.sync2;
    line_fall = s_q.line_prev && !rx_line;
    req = read || write;
    idx = address[5:2];
    wbyte = writedata[7:0];
  end

  assign link.tick = s_q.tick;
  assign link.start = s_q.tx_start;
  assign link.data = s_q.txbuf;
  assign link.nbits = nbits;
  assign link.par_en = parity_on;
  assign link.par_odd = parity_odd;
  assign link.two_stop = s_q.fmt_async[usart_ctrl_pkg::STOP_BIT_SEL];
  assign link.bit_len = bit_len_now;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.tx_start = 1'b0;
    s_d.wake = 1'b0;
    s_d.sync1 = rxd_in;
    s_d.sync2 = s_q.sync1;
    s_d.line_prev = rx_line;
    s_d.tick = (s_q.tick_cnt == TICK_LAST);
    s_d.tick_cnt = (s_q.tick_cnt == TICK_LAST) ? 8'h00 : 8'(s_q.tick_cnt + 8'h01);

    // Bus slave: answer one cycle after the request, act at the acknowledging edge
    if (req && s_q.wait_q) begin
      s_d.wait_q = 1'b0;
      unique case (idx)
        usart_ctrl_pkg::IDX_RX_DATA_LO: s_d.rdata = s_q.rxbuf[7:0];
        usart_ctrl_pkg::IDX_RX_DATA_HI: s_d.rdata = {s_q.rxbuf_valid, s_q.overrun_flag, 3'h0, s_q.framing_err_flag,
                                                     s_q.parity_err_flag, s_q.rxbuf[8]};
        usart_ctrl_pkg::IDX_STATUS: s_d.rdata = {s_q.rxbuf_valid, s_q.tx_done_flag, !s_q.txbuf_valid,
                                                 s_q.frame_start_flag, s_q.bad_sync_flag, 3'h0};
        usart_ctrl_pkg::IDX_CTRL_A: s_d.rdata = s_q.ctrl_a;
        usart_ctrl_pkg::IDX_CTRL_B: s_d.rdata = s_q.ctrl_b;
        usart_ctrl_pkg::IDX_CTRL_C: s_d.rdata = (s_q.comm_mode_sel == usart_ctrl_pkg::COMM_SPI_HOST)
                                                ? {s_q.comm_mode_sel, 3'h0, s_q.fmt_spi}
                                                : {s_q.comm_mode_sel, s_q.fmt_async};
        default: s_d.rdata = 8'h00;
      endcase
    end else if (!s_q.wait_q) begin
      s_d.wait_q = 1'b1;
      if (read && idx == usart_ctrl_pkg::IDX_RX_DATA_LO) begin
        s_d.rxbuf_valid = 1'b0;
      end
      if (write) begin
        unique case (idx)
          usart_ctrl_pkg::IDX_TX_DATA_LO: begin
            if (!s_q.txbuf_valid) begin
              s_d.txbuf[7:0] = wbyte;
              s_d.txbuf_valid = (char_width_sel != usart_ctrl_pkg::CHAR_NINE_LOW_FIRST);
            end
          end
          usart_ctrl_pkg::IDX_TX_DATA_HI: begin
            if (!s_q.txbuf_valid) begin
              s_d.txbuf[8] = wbyte[0];
              s_d.txbuf_valid = (char_width_sel == usart_ctrl_pkg::CHAR_NINE_LOW_FIRST);
            end
          end
          usart_ctrl_pkg::IDX_STATUS: begin
            if (wbyte[usart_ctrl_pkg::ST_TX_DONE]) begin
              s_d.tx_done_flag = 1'b0;
            end
            if (wbyte[usart_ctrl_pkg::ST_FRAME_START]) begin
              s_d.frame_start_flag = 1'b0;
            end
            if (wbyte[usart_ctrl_pkg::ST_BAD_SYNC]) begin
              s_d.bad_sync_flag = 1'b0;
              s_d.rx_state = RX_IDLE;
            end
          end
          usart_ctrl_pkg::IDX_CTRL_A: s_d.ctrl_a = wbyte;
          usart_ctrl_pkg::IDX_CTRL_B: s_d.ctrl_b = wbyte & usart_ctrl_pkg::CTRL_B_MASK;
          usart_ctrl_pkg::IDX_CTRL_C: begin
            s_d.comm_mode_sel = wbyte[7:6];
            if (wbyte[7:6] == usart_ctrl_pkg::COMM_SPI_HOST) begin
              s_d.fmt_spi = wbyte[2:0];
            end else begin
              s_d.fmt_async = wbyte[5:0];
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Transmit side: buffer to shifter, lingering enable, pin drive
    if (s_q.tx_enabled && s_q.txbuf_valid && !link.busy && !s_q.tx_start) begin
      s_d.tx_start = 1'b1;
      s_d.txbuf_valid = 1'b0;
    end
    if (link.done && !s_q.txbuf_valid) begin
      s_d.tx_done_flag = 1'b1;
    end
    if (s_q.ctrl_b[usart_ctrl_pkg::TRANSMITTER_ON]) begin
      s_d.tx_enabled = 1'b1;
    end else if (!link.busy && !s_q.txbuf_valid && !s_q.tx_start) begin
      s_d.tx_enabled = 1'b0;
    end
    s_d.txd_oe = s_q.tx_enabled
               && (rs485_sel != usart_ctrl_pkg::RS485_INT || link.busy)
               && !(s_q.ctrl_b[usart_ctrl_pkg::OPEN_DRAIN_EN] && link.line);
    s_d.txd = s_q.ctrl_b[usart_ctrl_pkg::OPEN_DRAIN_EN] ? 1'b0 : link.line;
    s_d.de = (rs485_sel == usart_ctrl_pkg::RS485_EXT) && link.busy;

    // Start-of-frame detection and wake-up
    if (s_q.ctrl_b[usart_ctrl_pkg::FRAME_START_WAKE_EN] && line_fall) begin
      s_d.wake = 1'b1;
      if (sleep_active) begin
        s_d.frame_start_flag = 1'b1;
      end
    end
    if (!s_q.ctrl_b[usart_ctrl_pkg::FRAME_START_WAKE_EN]) begin
      s_d.frame_start_flag = 1'b0;
    end

    // Receiver
    unique case (s_q.rx_state)
      RX_IDLE: begin
        if (line_fall && !s_q.bad_sync_flag) begin
          s_d.rx_cnt = 8'h00;
          s_d.edges = 3'h0;
          s_d.rx_state = (auto_mode && !s_q.synced) ? RX_SYNC : RX_START;
        end
      end
      RX_SYNC: begin
        if (line_fall) begin
          s_d.rx_cnt = 8'h00;
          if (s_q.rx_cnt < two_bit_min || s_q.rx_cnt > two_bit_max) begin
            s_d.bad_sync_flag = 1'b1;
            s_d.rx_state = RX_IDLE;
          end else if (s_q.edges == 3'(usart_ctrl_pkg::SYNC_INTERVALS - 3'h1)) begin
            s_d.synced = 1'b1;
            s_d.bit_len = {1'b0, s_q.rx_cnt[7:1]};
            s_d.rx_state = RX_IDLE;
          end else begin
            s_d.edges = 3'(s_q.edges + 3'h1);
          end
        end else if (s_q.tick) begin
          if (s_q.rx_cnt == two_bit_max) begin
            s_d.bad_sync_flag = 1'b1;
            s_d.rx_state = RX_IDLE;
          end else begin
            s_d.rx_cnt = 8'(s_q.rx_cnt + 8'h01);
          end
        end
      end
      RX_START: begin
        if (s_q.tick) begin
          if (s_q.rx_cnt == {1'b0, bit_len_now[7:1]}) begin
            s_d.rx_cnt = 8'h00;
            s_d.rx_bits = 4'h0;
            s_d.rx_shift = 9'h000;
            s_d.rx_par = 1'b0;
            s_d.rx_parity_err_flag = 1'b0;
            s_d.rx_state = rx_line ? RX_IDLE : RX_DATA;
          end else begin
            s_d.rx_cnt = 8'(s_q.rx_cnt + 8'h01);
          end
        end
      end
      RX_DATA, RX_PARITY, RX_STOP: begin
        if (s_q.tick) begin
          if (s_q.rx_cnt == 8'(bit_len_now - 8'h01)) begin
            s_d.rx_cnt = 8'h00;
            if (s_q.rx_state == RX_DATA) begin
              s_d.rx_shift[s_q.rx_bits] = rx_line;
              s_d.rx_par = s_q.rx_par ^ rx_line;
              s_d.rx_bits = 4'(s_q.rx_bits + 4'h1);
              if (s_q.rx_bits == 4'(nbits - 4'h1)) begin
                s_d.rx_state = parity_on ? RX_PARITY : RX_STOP;
              end
            end else if (s_q.rx_state == RX_PARITY) begin
              s_d.rx_parity_err_flag = rx_line != (s_q.rx_par ^ parity_odd);
              s_d.rx_state = RX_STOP;
            end else begin
              s_d.rx_state = RX_IDLE;
              if (!(s_q.ctrl_b[usart_ctrl_pkg::ADDRESS_FRAME_FILTER] && !s_q.rx_shift[nbits - 4'h1])) begin
                if (s_d.rxbuf_valid) begin
                  s_d.overrun_flag = 1'b1;
                end else begin
                  s_d.rxbuf = s_q.rx_shift;
                  s_d.rxbuf_valid = 1'b1;
                  s_d.framing_err_flag = !rx_line;
                  s_d.parity_err_flag = s_q.rx_parity_err_flag && parity_on;
                  s_d.overrun_flag = 1'b0;
                end
              end
            end
          end else begin
            s_d.rx_cnt = 8'(s_q.rx_cnt + 8'h01);
          end
        end
      end
    endcase
    if (!s_q.ctrl_b[usart_ctrl_pkg::RECEIVER_ON]) begin
      s_d.rx_state = RX_IDLE;
      s_d.rxbuf_valid = 1'b0;
      s_d.framing_err_flag = 1'b0;
      s_d.parity_err_flag = 1'b0;
      s_d.overrun_flag = 1'b0;
      s_d.synced = 1'b0;
    end
    if (!auto_mode) begin
      s_d.synced = 1'b0;
    end

    // Interrupt lines
    s_d.irq_rx = (s_q.ctrl_a[usart_ctrl_pkg::RX_DONE_IRQ_EN] && s_q.rxbuf_valid)
               || (s_q.ctrl_a[usart_ctrl_pkg::FRAME_START_IRQ_EN] && s_q.frame_start_flag)
               || (s_q.ctrl_a[usart_ctrl_pkg::BAUD_DETECT_ERR_IRQ_EN] && s_q.bad_sync_flag);
    s_d.irq_tx = s_q.ctrl_a[usart_ctrl_pkg::TX_DONE_IRQ_EN] && s_q.tx_done_flag;
    s_d.irq_dre = s_q.ctrl_a[usart_ctrl_pkg::TX_EMPTY_IRQ_EN] && !s_q.txbuf_valid;

    if (!reset_n) begin
      s_d = '0;
      s_d.ctrl_a = usart_ctrl_pkg::CTRL_A_RESET;
      s_d.ctrl_b = usart_ctrl_pkg::CTRL_B_RESET;
      s_d.comm_mode_sel = usart_ctrl_pkg::COMM_ASYNC;
      s_d.fmt_async = usart_ctrl_pkg::FMT_ASYNC_RESET;
      s_d.fmt_spi = usart_ctrl_pkg::FMT_SPI_RESET;
      s_d.wait_q = 1'b1;
      s_d.rx_state = RX_IDLE;
      s_d.bit_len = usart_ctrl_pkg::SAMPLES_NORMAL;
      s_d.txd = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  // ==========================================================================
  // Outputs
  assign readdata = {24'h000000, s_q.rdata};
  assign waitrequest = s_q.wait_q;
  assign txd_out = s_q.txd;
  assign txd_oe = s_q.txd_oe;
  assign driver_enable_pin = s_q.de;
  assign rx_pin_owned = s_q.ctrl_b[usart_ctrl_pkg::RECEIVER_ON];
  assign wake_req = s_q.wake;
  assign rx_vector_irq = s_q.irq_rx;
  assign tx_vector_irq = s_q.irq_tx;
  assign empty_vector_irq = s_q.irq_dre;
endmodule

// *** usart_control_config_props.sv ***
// Port-level checker for the serial transceiver control block
`timescale 1ns/10ps
module usart_control_config_props #(
  parameter int SAMPLE_DIV = 4
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic driver_enable_pin,
  input wire logic rx_pin_owned,
  input wire logic wake_req,
  input wire logic rx_vector_irq,
  input wire logic tx_vector_irq,
  input wire logic empty_vector_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Shadow copies of control registers A and B
  logic [7:0] sa_q;
  logic [7:0] sb_q;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sa_q <= 8'h00;
      sb_q <= 8'h00;
    end else if (write && !waitrequest && address[5:2] == 4'h5) begin
      sa_q <= writedata[7:0];
    end else if (write && !waitrequest && address[5:2] == 4'h6) begin
      sb_q <= writedata[7:0];
    end
  end
  // ==========================================
  // Properties
  sequence req_taken;
    (read || write) && waitrequest;
  endsequence
  sequence ack_once;
    !waitrequest ##1 waitrequest;
  endsequence
  bus_ack_once_a: assert property (req_taken |=> ack_once) else $error("bus answer not one cycle");
  read_data_a: assert property (!waitrequest && read |-> readdata[31:8] == 24'h0
    && (!address[5] || readdata[7:0] == 8'h00)) else $error("read data wrong");
  rx_irq_gate_a: assert property (!(sa_q[7] || sa_q[4] || sa_q[2]) [*3] |-> !rx_vector_irq)
    else $error("receive irq while disabled");
  tx_irq_gate_a: assert property (!sa_q[6] [*3] |-> !tx_vector_irq) else $error("transmit irq while disabled");
  empty_irq_gate_a: assert property (!sa_q[5] [*3] |-> !empty_vector_irq) else $error("empty irq while disabled");
  rx_owner_a: assert property (rx_pin_owned != sb_q[7] |=> rx_pin_owned == sb_q[7])
    else $error("receive pin owner lags");
  tx_drive_a: assert property ($rose(txd_oe) |-> $past(sb_q[6])) else $error("pin driven while off");
  wake_pulse_a: assert property (wake_req |=> !wake_req) else $error("wake longer than one cycle");
  wake_gate_a: assert property (wake_req |-> $past(sb_q[4])) else $error("wake while disabled");
  open_drain_a: assert property (sb_q[3] && $past(sb_q[3]) && txd_oe |-> !txd_out)
    else $error("open drain drove high");
  driver_mode_a: assert property ($rose(driver_enable_pin) |-> sa_q[1:0] == 2'h1)
    else $error("driver enable outside external mode");
endmodule
bind usart_control_config usart_control_config_props #(.SAMPLE_DIV(SAMPLE_DIV)) usart_control_config_props_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .txd_out(txd_out),
  .txd_oe(txd_oe), .driver_enable_pin(driver_enable_pin), .rx_pin_owned(rx_pin_owned),
  .wake_req(wake_req), .rx_vector_irq(rx_vector_irq), .tx_vector_irq(tx_vector_irq),
  .empty_vector_irq(empty_vector_irq));

// *** serial_node.sv ***
// Remote serial node: sends frames on the receive line, captures transmitted frames
`timescale 1ns/10ps
module serial_node #(
  parameter int BIT_CLKS = 64
) (
  input wire logic clk_sys,
  input wire logic txd_out,
  input wire logic txd_oe,
  output logic rxd_line
);
  logic line;
  // Pulled up while released
  assign line = txd_oe ? txd_out : 1'b1;
  initial rxd_line = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_line <= f[i];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
  endtask
  task automatic grab(output logic [9:0] f);
    int n;
    n = 0;
    while (line === 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (BIT_CLKS / 2) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      f[i] = line;
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
  endtask
endmodule

// *** usart_control_config_tb.sv ***
// Self-checking bench for the serial transceiver control block
`timescale 1ns/10ps
module usart_control_config_tb;
  localparam int DIV = 2;
  logic clk_sys, reset_n, read, write, rxd_in, sleep_active, waitrequest, txd_out, txd_oe, de;
  logic driver_enable_pin, rx_pin_owned, wake_req, rx_vector_irq, tx_vector_irq, empty_vector_irq;
  logic [5:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [9:0] fr;
  logic [7:0] b;
  logic [7:0] cfg [4] = '{8'h03, 8'h23, 8'h33, 8'h00};
  int num_errors, samples_checked, cyc;
  usart_control_config #(.SAMPLE_DIV(DIV)) usart_control_config_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rxd_in(rxd_in), .sleep_active(sleep_active), .txd_out(txd_out),
    .txd_oe(txd_oe), .driver_enable_pin(driver_enable_pin), .rx_pin_owned(rx_pin_owned),
    .wake_req(wake_req), .rx_vector_irq(rx_vector_irq), .tx_vector_irq(tx_vector_irq),
    .empty_vector_irq(empty_vector_irq));
  serial_node #(.BIT_CLKS(16 * DIV)) serial_node_i (.clk_sys(clk_sys), .txd_out(txd_out),
    .txd_oe(txd_oe), .rxd_line(rxd_in));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    write <= wr;
    read <= !wr;
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    @(posedge clk_sys);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask
  task automatic wait_for(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    check(s, 1'b1);
  endtask
  function automatic logic [9:0] frame_of(input logic [7:0] c, input logic [7:0] d);
    logic [9:0] f;
    logic p;
    f = 10'h3fe;
    p = c[4];
    for (int i = 0; i < 5 + c[1:0]; i++) begin
      f[i + 1] = d[i];
      p = p ^ d[i];
    end
    if (c[5]) f[6 + c[1:0]] = p;
    return f;
  endfunction
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    {reset_n, read, write, sleep_active} = 4'h0;
    address = 6'h00;
    writedata = 32'h0;
    void'($urandom(32'hc2922ae5));
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdchk(4'h5, 32'h00);
    rdchk(4'h6, 32'h00);
    rdchk(4'h7, 32'h03);
    rdchk(4'h4, 32'h20);
    rdchk(4'h9, 32'h00);
    for (int k = 0; k < 6; k++) begin
      b = $urandom;
      wr(4'h5, b);
      rdchk(4'h5, {24'h0, b});
      b = $urandom;
      wr(4'h6, b & 8'hd9);
      rdchk(4'h6, {24'h0, b & 8'hd9});
      b = $urandom;
      wr(4'h7, b & 8'hbf);
      rdchk(4'h7, {24'h0, b & 8'hbf});
    end
    wr(4'h7, 8'hc5);
    rdchk(4'h7, 32'hc5);
    wr(4'h7, 8'h03);
    rdchk(4'h7, 32'h03);
    wr(4'h6, 8'h00);
    wr(4'h4, 8'h58);
    wr(4'h5, 8'h20);
    wait_for(empty_vector_irq, 10);
    wr(4'h5, 8'h61);
    wr(4'h6, 8'h48);
    foreach (cfg[k]) begin
      wr(4'h7, cfg[k]);
      b = $urandom;
      fork
        serial_node_i.grab(fr);
        wr(4'h2, b);
        begin
          repeat (100) @(posedge clk_sys);
          de = driver_enable_pin;
        end
      join
      check(fr, frame_of(cfg[k], b));
      check(de, 1'b1);
      wait_for(tx_vector_irq, 400);
      repeat (4) @(posedge clk_sys);
      check(driver_enable_pin, 1'b0);
      wr(4'h4, 8'h40);
    end
    wr(4'h5, 8'h88);
    wr(4'h6, 8'hc0);
    wr(4'h7, 8'h03);
    b = $urandom;
    wr(4'h2, b);
    wait_for(rx_vector_irq, 600);
    rdchk(4'h1, 32'h80);
    rdchk(4'h0, {24'h0, b});
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h90);
    sleep_active <= 1'b1;
    b = $urandom;
    fork
      serial_node_i.send(b);
      wait_for(wake_req, 40);
    join
    rdchk(4'h0, {24'h0, b});
    tally_and_finish();
  end
endmodule
